// ===== logic/dct_pkg.sv
// Purpose: Shared constants for the digital connector timing and pin routing block.
// Assumes: 50 MHz system clock; all connector inputs synchronous to it.
// Notes:   Pulse widths are given in ns and turned into cycle counts here.

package dct_pkg;

  // ==========================================================================
  // Clock and pulse timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Least width of a strobe pulse on a connector output
  localparam int unsigned PULSE_NS      = 100;
  // Least time rounds up to whole cycles
  localparam int unsigned PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W   = 4;

  // ==========================================================================
  // General line layout
  // ==========================================================================
  localparam int unsigned GEN_LINES     = 8;
  localparam int unsigned CTR0_DIR_LINE = 6;
  localparam int unsigned CTR1_DIR_LINE = 7;
  localparam int unsigned FUNC_IN_W     = 8;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic        RST_FIXED_HIGH = 1'b1;
  localparam logic        RST_STROBE_N   = 1'b1;
  localparam logic        RST_ACTIVE_N   = 1'b1;
  localparam logic        RST_PIN_OUT    = 1'b0;
  localparam logic        RST_OE_N       = 1'b1;
  localparam logic        RST_COUNT_UP   = 1'b1;
  // Pulled-up pin idles high, so the edge detector starts high
  localparam logic        RST_PIN_IDLE   = 1'b1;

endpackage : dct_pkg

// ===== logic/dct_connector_io.sv
// Purpose: Digital connector routing: general lines, strobe, function pins, echoes.
// Assumes: Single 50 MHz clock, inputs synchronous, pin enables active low.
// Notes:   No software registers; all configuration arrives on plain inputs.

`timescale 1ns/1ps

// ============================================================================
// Pulse stretcher: one-cycle event to a fixed-width level pulse
// ============================================================================
module dct_pulse_stretch #(
  parameter logic IDLE = 1'b0
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic fire,
  output logic      pulse_q
);
  logic [dct_pkg::PULSE_CNT_W-1:0] cnt_q;
  logic [dct_pkg::PULSE_CNT_W-1:0] cnt_d;
  logic                            pulse_d;

  // A fire during a pulse restarts the width, so no second edge appears
  always_comb begin
    cnt_d   = cnt_q;
    pulse_d = IDLE;
    if (fire) begin
      cnt_d   = dct_pkg::PULSE_CNT_W'(dct_pkg::PULSE_CYC);
      pulse_d = ~IDLE;
    end else if (cnt_q != '0) begin
      cnt_d   = cnt_q - 1'b1;
      pulse_d = (cnt_q > 1) ? ~IDLE : IDLE;
    end
  end

  // State registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= '0;
      pulse_q <= IDLE;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end
endmodule : dct_pulse_stretch

// ============================================================================
// Top: connector routing
// ============================================================================
module dct_connector_io (
  input  wire logic       clock,
  input  wire logic       nrst,
  // General lines
  input  wire logic [7:0] general_lines_in,
  input  wire logic [7:0] general_lines_data,
  input  wire logic [7:0] general_lines_dir,
  output logic      [7:0] general_lines_out,
  output logic      [7:0] general_lines_oe_n,
  input  wire logic [1:0] ctr_dir_from_line,
  input  wire logic [1:0] ctr_dir_internal,
  output logic            counter0_count_up,
  output logic            counter1_count_up,
  // Fixed output and strobe
  output logic            fixed_high_output,
  input  wire logic       strobe_toggle,
  output logic            external_strobe_n,
  // Acquisition start
  input  wire logic       acq_start_pin_dir,
  input  wire logic       acq_start_from_pin,
  input  wire logic       acq_start_internal,
  input  wire logic       acq_start_trigger_pin_in,
  output logic            acq_start_trigger_pin_out,
  output logic            acq_start_trigger_pin_oe_n,
  output logic            external_start_trigger,
  output logic            acq_start_trigger,
  // Posttrigger marker
  input  wire logic       posttrig_pin_dir,
  input  wire logic       pretrigger_marker,
  input  wire logic       acq_running,
  input  wire logic       posttrig_begin,
  input  wire logic       acq_posttrigger_pin_in,
  output logic            acq_posttrigger_pin_out,
  output logic            acq_posttrigger_pin_oe_n,
  output logic            posttrigger_marker,
  // Conversion and update strobes
  input  wire logic       adc_convert_event,
  input  wire logic       dac_update_event,
  output logic            adc_convert_n,
  output logic            dac_update_n,
  // Waveform start
  input  wire logic       waveform_pin_dir,
  input  wire logic       waveform_running,
  input  wire logic       waveform_begin,
  input  wire logic       waveform_start_pin_in,
  output logic            waveform_start_pin_out,
  output logic            waveform_start_pin_oe_n,
  output logic            waveform_start_trigger,
  // Counter echoes
  input  wire logic [1:0] ctr_source_dir,
  input  wire logic [1:0] ctr_gate_dir,
  input  wire logic [1:0] ctr_source_sel,
  input  wire logic [1:0] ctr_gate_sel,
  input  wire logic       counter0_source_echo_in,
  input  wire logic       counter0_gate_echo_in,
  input  wire logic       counter1_source_echo_in,
  input  wire logic       counter1_gate_echo_in,
  output logic            counter0_source_echo,
  output logic            counter0_source_echo_oe_n,
  output logic            counter0_gate_echo,
  output logic            counter0_gate_echo_oe_n,
  output logic            counter1_source_echo,
  output logic            counter1_source_echo_oe_n,
  output logic            counter1_gate_echo,
  output logic            counter1_gate_echo_oe_n,
  // Counter and frequency outputs
  input  wire logic       counter0_out_int,
  input  wire logic       counter1_out_int,
  input  wire logic       freq_gen_out,
  output logic            counter0_result,
  output logic            counter1_result,
  output logic            divided_clock_output,
  // Function pin input levels
  input  wire logic       function_input_seven,
  output logic      [7:0] func_in_levels
);

  logic       fixed_d, strobe_d;
  logic [7:0] gl_out_d, gl_oe_n_d, fin_d;
  logic       up0_d, up1_d;
  logic       acq_prev_q, acq_pin_rise, external_start_trigger_d, acq_trig_d;
  logic       post_d, wave_d;
  logic [7:0] oe_n_d, oe_n_q;
  logic [3:0] echo_d, echo_q;
  logic [2:0] res_d;
  logic       acq_pulse;

  // ==========================================================================
  // General lines, direction control, fixed output and strobe
  // ==========================================================================
  always_comb begin
    gl_out_d  = general_lines_data;
    gl_oe_n_d = ~general_lines_dir;
    // Line used as direction is sampled; the block still drives it whenever its general_lines_dir bit is set
    up0_d = ctr_dir_from_line[0] ? general_lines_in[dct_pkg::CTR0_DIR_LINE]
                                 : ctr_dir_internal[0];
    up1_d = ctr_dir_from_line[1] ? general_lines_in[dct_pkg::CTR1_DIR_LINE]
                                 : ctr_dir_internal[1];
    fixed_d  = dct_pkg::RST_FIXED_HIGH;
    strobe_d = strobe_toggle ? ~external_strobe_n : external_strobe_n;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      general_lines_out  <= '0;
      general_lines_oe_n <= '1;
      counter0_count_up  <= dct_pkg::RST_COUNT_UP;
      counter1_count_up  <= dct_pkg::RST_COUNT_UP;
      fixed_high_output  <= dct_pkg::RST_FIXED_HIGH;
      external_strobe_n  <= dct_pkg::RST_STROBE_N;
    end else begin
      general_lines_out  <= gl_out_d;
      general_lines_oe_n <= gl_oe_n_d;
      counter0_count_up  <= up0_d;
      counter1_count_up  <= up1_d;
      fixed_high_output  <= fixed_d;
      external_strobe_n  <= strobe_d;
    end
  end

  // ==========================================================================
  // Acquisition start, posttrigger and waveform markers
  // ==========================================================================
  // Pin edge only counts while the pin is an input
  assign acq_pin_rise = acq_start_trigger_pin_in & ~acq_prev_q & ~acq_start_pin_dir;

  always_comb begin
    external_start_trigger_d = acq_start_from_pin & acq_pin_rise;
    acq_trig_d = acq_start_from_pin ? acq_pin_rise : acq_start_internal;
    // Marker cleared when the run ends; ignored in posttrigger-only runs
    post_d = posttrigger_marker;
    if (!acq_running || !pretrigger_marker) begin
      post_d = 1'b0;
    end else if (posttrig_begin) begin
      post_d = 1'b1;
    end
    wave_d = waveform_start_trigger;
    if (!waveform_running) begin
      wave_d = 1'b0;
    end else if (waveform_begin) begin
      wave_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acq_prev_q             <= dct_pkg::RST_PIN_IDLE; // No false edge after reset
      external_start_trigger <= 1'b0;
      acq_start_trigger      <= 1'b0;
      posttrigger_marker     <= 1'b0;
      waveform_start_trigger <= 1'b0;
    end else begin
      acq_prev_q             <= acq_start_trigger_pin_in;
      external_start_trigger <= external_start_trigger_d;
      acq_start_trigger      <= acq_trig_d;
      posttrigger_marker     <= post_d;
      waveform_start_trigger <= wave_d;
    end
  end

  // ==========================================================================
  // Fixed-width pulses: start echo, conversion and update strobes
  // ==========================================================================
  dct_pulse_stretch #(.IDLE(1'b0)) u_acq_pulse (
    .clock   (clock),
    .nrst    (nrst),
    .fire    (acq_trig_d),
    .pulse_q (acq_pulse)
  );
  dct_pulse_stretch #(.IDLE(dct_pkg::RST_ACTIVE_N)) u_conv_pulse (
    .clock   (clock),
    .nrst    (nrst),
    .fire    (adc_convert_event),
    .pulse_q (adc_convert_n)
  );
  dct_pulse_stretch #(.IDLE(dct_pkg::RST_ACTIVE_N)) u_upd_pulse (
    .clock   (clock),
    .nrst    (nrst),
    .fire    (dac_update_event),
    .pulse_q (dac_update_n)
  );

  // ==========================================================================
  // Function pin drivers, echoes and dedicated outputs
  // ==========================================================================
  always_comb begin
    // Enable order: acq, post, wave, src0, gate0, src1, gate1, spare
    oe_n_d = {1'b1, ~ctr_gate_dir[1], ~ctr_source_dir[1], ~ctr_gate_dir[0],
              ~ctr_source_dir[0], ~waveform_pin_dir, ~posttrig_pin_dir,
              ~acq_start_pin_dir};
    // Selected echo input, or low when the routing does not select it
    echo_d[0] = ctr_source_sel[0] ? counter0_source_echo_in : 1'b0;
    echo_d[1] = ctr_gate_sel[0] ? counter0_gate_echo_in : 1'b0;
    echo_d[2] = ctr_source_sel[1] ? counter1_source_echo_in : 1'b0;
    echo_d[3] = ctr_gate_sel[1] ? counter1_gate_echo_in : 1'b0;
    res_d     = {freq_gen_out, counter1_out_int, counter0_out_int};
    fin_d     = {counter0_gate_echo_in, counter0_source_echo_in, function_input_seven,
                 waveform_start_pin_in, counter1_gate_echo_in, counter1_source_echo_in,
                 acq_posttrigger_pin_in, acq_start_trigger_pin_in};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oe_n_q               <= '1;
      echo_q               <= '0;
      counter0_result      <= 1'b0;
      counter1_result      <= 1'b0;
      divided_clock_output <= 1'b0;
      func_in_levels       <= '0;
    end else begin
      oe_n_q               <= oe_n_d;
      echo_q               <= echo_d;
      counter0_result      <= res_d[0];
      counter1_result      <= res_d[1];
      divided_clock_output <= res_d[2];
      func_in_levels       <= fin_d;
    end
  end

  assign acq_start_trigger_pin_out  = acq_pulse;
  assign acq_start_trigger_pin_oe_n = oe_n_q[0];
  assign acq_posttrigger_pin_out    = posttrigger_marker;
  assign acq_posttrigger_pin_oe_n   = oe_n_q[1];
  assign waveform_start_pin_out     = waveform_start_trigger;
  assign waveform_start_pin_oe_n    = oe_n_q[2];
  assign counter0_source_echo       = echo_q[0];
  assign counter0_source_echo_oe_n  = oe_n_q[3];
  assign counter0_gate_echo         = echo_q[1];
  assign counter0_gate_echo_oe_n    = oe_n_q[4];
  assign counter1_source_echo       = echo_q[2];
  assign counter1_source_echo_oe_n  = oe_n_q[5];
  assign counter1_gate_echo         = echo_q[3];
  assign counter1_gate_echo_oe_n    = oe_n_q[6];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_low_five;
    (!adc_convert_n) [*5];
  endsequence
  sequence s_upd_low_five;
    (!dac_update_n) [*5];
  endsequence
  // A later event restarts the width, so rest is only owed after a quiet run
  sequence s_conv_quiet;
    (!adc_convert_event) [*5];
  endsequence
  sequence s_upd_quiet;
    (!dac_update_event) [*5];
  endsequence

  property p_dir_line0;
    @(posedge clock) disable iff (!nrst)
      ctr_dir_from_line[0] |=> counter0_count_up == $past(general_lines_in[6]);
  endproperty
  a_dir_line0: assert property (p_dir_line0) else $error("counter0 direction wrong");

  property p_dir_line1;
    @(posedge clock) disable iff (!nrst)
      ctr_dir_from_line[1] |=> counter1_count_up == $past(general_lines_in[7]);
  endproperty
  a_dir_line1: assert property (p_dir_line1) else $error("counter1 direction wrong");

  property p_fixed_high;
    @(posedge clock) disable iff (!nrst) fixed_high_output;
  endproperty
  a_fixed_high: assert property (p_fixed_high) else $error("reserved output low");

  property p_strobe;
    @(posedge clock) disable iff (!nrst)
      strobe_toggle |=> external_strobe_n != $past(external_strobe_n);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe did not toggle");

  property p_ext_start;
    @(posedge clock) disable iff (!nrst)
      (acq_start_from_pin && !acq_start_pin_dir && acq_start_trigger_pin_in && !acq_prev_q)
      |=> acq_start_trigger && external_start_trigger;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("pin start missed");

  property p_start_echo;
    @(posedge clock) disable iff (!nrst)
      acq_start_trigger |-> acq_start_trigger_pin_out;
  endproperty
  a_start_echo: assert property (p_start_echo) else $error("start echo missing");

  property p_post_pretrigger_marker;
    @(posedge clock) disable iff (!nrst)
      $rose(posttrigger_marker) |-> $past(pretrigger_marker) && $past(posttrig_begin);
  endproperty
  a_post_pretrigger_marker: assert property (p_post_pretrigger_marker) else $error("posttrigger rise bad");

  property p_convert;
    @(posedge clock) disable iff (!nrst)
      adc_convert_event |=> s_low_five;
  endproperty
  a_convert: assert property (p_convert) else $error("convert pulse wrong");

  property p_convert_rest;
    @(posedge clock) disable iff (!nrst)
      adc_convert_event ##1 s_conv_quiet |=> adc_convert_n;
  endproperty
  a_convert_rest: assert property (p_convert_rest) else $error("convert stuck low");

  property p_update;
    @(posedge clock) disable iff (!nrst)
      dac_update_event |=> s_upd_low_five;
  endproperty
  a_update: assert property (p_update) else $error("update pulse wrong");

  property p_update_rest;
    @(posedge clock) disable iff (!nrst)
      dac_update_event ##1 s_upd_quiet |=> dac_update_n;
  endproperty
  a_update_rest: assert property (p_update_rest) else $error("update stuck low");

  property p_wave;
    @(posedge clock) disable iff (!nrst)
      (waveform_running && waveform_begin) |=> waveform_start_trigger;
  endproperty
  a_wave: assert property (p_wave) else $error("waveform start missed");

  property p_src_echo;
    @(posedge clock) disable iff (!nrst)
      ctr_source_sel[0] |=> counter0_source_echo == $past(counter0_source_echo_in);
  endproperty
  a_src_echo: assert property (p_src_echo) else $error("source echo wrong");

  property p_gate_echo;
    @(posedge clock) disable iff (!nrst)
      ctr_gate_sel[1] |=> counter1_gate_echo == $past(counter1_gate_echo_in);
  endproperty
  a_gate_echo: assert property (p_gate_echo) else $error("gate echo wrong");

  property p_results;
    @(posedge clock) disable iff (!nrst)
      ##1 (counter0_result == $past(counter0_out_int))
          && (counter1_result == $past(counter1_out_int))
          && (divided_clock_output == $past(freq_gen_out));
  endproperty
  a_results: assert property (p_results) else $error("dedicated output lag wrong");

endmodule : dct_connector_io

// ===== test/dct_ext_model.sv
// Purpose: Connector-side instruments and wiring for the connector routing block.
// Assumes: Every connector pin has a pull-up; the block drives a pin while its oe_n is low.
// Notes:   A released pin reads high, as the pull-up leaves it; contention reads unknown.

`timescale 1ns/1ps

// ============================================================================
// Far-side drivers and wire resolution
// ============================================================================
module dct_ext_model #(
  parameter int W = 11
) (
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe_n,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] level
);
  // Two drivers at once is a wiring fault, so show it as unknown
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level[i] = (!dev_oe_n[i] && ext_en[i]) ? 1'bx :
                 !dev_oe_n[i] ? dev_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : dct_ext_model

// ===== test/dct_connector_io_tb_top.sv
// Purpose: Self-checking bench for the digital connector routing block.
// Assumes: Inputs change 2 ns after the rising edge; registered outputs lag one cycle.
// Notes:   Echo sources are driven straight from the bench to avoid a pin feedback loop.

`timescale 1ns/1ps

module dct_connector_io_tb_top;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clock = 1'b0;
  logic        nrst  = 1'b0;
  logic [7:0]  general_lines_in, general_lines_data, general_lines_dir;
  logic [7:0]  general_lines_out, general_lines_oe_n;
  logic [1:0]  ctr_dir_from_line, ctr_dir_internal, ctr_source_dir, ctr_gate_dir;
  logic [1:0]  ctr_source_sel, ctr_gate_sel;
  logic        counter0_count_up, counter1_count_up, fixed_high_output, strobe_toggle;
  logic        external_strobe_n, acq_start_pin_dir, acq_start_from_pin, acq_start_internal;
  logic        acq_start_trigger_pin_in, acq_start_trigger_pin_out, acq_start_trigger_pin_oe_n;
  logic        external_start_trigger, acq_start_trigger, posttrig_pin_dir, pretrigger_marker;
  logic        acq_running, posttrig_begin, acq_posttrigger_pin_in, acq_posttrigger_pin_out;
  logic        acq_posttrigger_pin_oe_n, posttrigger_marker, adc_convert_event, dac_update_event;
  logic        adc_convert_n, dac_update_n, waveform_pin_dir, waveform_running, waveform_begin;
  logic        waveform_start_pin_in, waveform_start_pin_out, waveform_start_pin_oe_n;
  logic        waveform_start_trigger, counter0_source_echo_in, counter0_gate_echo_in;
  logic        counter1_source_echo_in, counter1_gate_echo_in, counter0_source_echo;
  logic        counter0_source_echo_oe_n, counter0_gate_echo, counter0_gate_echo_oe_n;
  logic        counter1_source_echo, counter1_source_echo_oe_n, counter1_gate_echo;
  logic        counter1_gate_echo_oe_n, counter0_out_int, counter1_out_int, freq_gen_out;
  logic        counter0_result, counter1_result, divided_clock_output, function_input_seven;
  logic [10:0] pin_lvl, ext_en, ext_val;
  logic [5:0]  watch;
  logic [7:0]  func_in_levels;
  int          error_cnt    = 0;
  int          total_checks = 0;

  // Clock, 50 MHz
  always #10 clock = ~clock;

  // ==========================================================================
  // Design, far side and wiring
  // ==========================================================================
  dct_connector_io dut (.*);

  dct_ext_model #(.W(11)) ext (
    .dev_out  ({waveform_start_pin_out, acq_posttrigger_pin_out, acq_start_trigger_pin_out,
                general_lines_out}),
    .dev_oe_n ({waveform_start_pin_oe_n, acq_posttrigger_pin_oe_n, acq_start_trigger_pin_oe_n,
                general_lines_oe_n}),
    .ext_en   (ext_en),
    .ext_val  (ext_val),
    .level    (pin_lvl)
  );

  // Pin levels back into the block
  assign general_lines_in         = pin_lvl[7:0];
  assign acq_start_trigger_pin_in = pin_lvl[8];
  assign acq_posttrigger_pin_in   = pin_lvl[9];
  assign waveform_start_pin_in    = pin_lvl[10];
  assign watch = {pin_lvl[8], dac_update_n, adc_convert_n, waveform_start_trigger,
                  posttrigger_marker, acq_start_trigger};

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Bounded wait; running out counts a mismatch and ends the run
  task automatic wait_on(input int idx, input logic lvl);
    int n;
    n = 0;
    while (watch[idx] !== lvl && n < 8) begin
      tick(1);
      n++;
    end
    check(watch[idx], lvl);
    if (n == 8) complete_run();
  endtask : wait_on

  // Width of a pulse already under way, in whole cycles
  task automatic measure(input int idx, input logic lvl);
    int n;
    n = 0;
    while (watch[idx] === lvl && n < 12) begin
      tick(1);
      n++;
    end
    check(8'(n), 8'(dct_pkg::PULSE_CYC));
  endtask : measure

  // Reserved output is watched every cycle, reset included
  always @(negedge clock) check(fixed_high_output, 1'b1);

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    check({adc_convert_n, dac_update_n}, 2'b11);
    check({external_strobe_n, counter0_count_up, counter1_count_up}, 3'b111);
    check(general_lines_oe_n, 8'hff);
  endtask : t_reset

  // Held request is two back-to-back toggles
  task automatic t_strobe;
    strobe_toggle = 1'b1;
    tick(1);
    check(external_strobe_n, 1'b0);
    tick(1);
    strobe_toggle = 1'b0;
    check(external_strobe_n, 1'b1);
    tick(2);
    check(external_strobe_n, 1'b1);
  endtask : t_strobe

  // Lines 2..5 driven by the block, 0,1,6,7 by the far side
  task automatic t_lines;
    general_lines_dir  = 8'h3c;
    general_lines_data = 8'ha5;
    ext_en[7:0]        = 8'hc3;
    ctr_dir_from_line  = 2'b11;
    for (int k = 0; k < 4; k++) begin
      ext_val[7:6] = k[1:0];
      tick(2);
      check({counter1_count_up, counter0_count_up}, k[1:0]);
    end
    check(general_lines_out, 8'ha5);
    check(general_lines_oe_n, 8'hc3);
    ctr_dir_from_line = 2'b00;
    for (int k = 0; k < 4; k++) begin
      ctr_dir_internal = k[1:0];
      tick(2);
      check({counter1_count_up, counter0_count_up}, k[1:0]);
    end
  endtask : t_lines

  task automatic t_start;
    acq_start_from_pin = 1'b1;
    ext_en[8]          = 1'b1;
    tick(3);
    check(acq_start_trigger, 1'b0);
    ext_val[8] = 1'b1;
    wait_on(0, 1'b1);
    check({external_start_trigger, acq_start_trigger_pin_oe_n}, 2'b11);
    tick(1);
    check({acq_start_trigger, external_start_trigger}, 2'b00);
    // Far side lets go first so the pull-up cannot fake a pulse
    ext_en[8]          = 1'b0;
    acq_start_pin_dir  = 1'b1;
    acq_start_from_pin = 1'b0;
    // Start echo from the pin edge must have run out first
    tick(4);
    check({pin_lvl[8], acq_start_trigger_pin_oe_n}, 2'b00);
    acq_start_internal = 1'b1;
    tick(1);
    acq_start_internal = 1'b0;
    wait_on(5, 1'b1);
    measure(5, 1'b1);
  endtask : t_start

  // Posttrigger-only run first, then a pretrigger run
  task automatic t_post;
    posttrig_pin_dir = 1'b1;
    acq_running      = 1'b1;
    posttrig_begin   = 1'b1;
    tick(1);
    posttrig_begin = 1'b0;
    tick(2);
    check({posttrigger_marker, pin_lvl[9]}, 2'b00);
    pretrigger_marker = 1'b1;
    posttrig_begin    = 1'b1;
    tick(1);
    posttrig_begin = 1'b0;
    wait_on(1, 1'b1);
    check({pin_lvl[9], acq_posttrigger_pin_oe_n}, 2'b10);
  endtask : t_post

  task automatic t_wave;
    waveform_pin_dir = 1'b1;
    waveform_begin   = 1'b1;
    tick(1);
    waveform_begin = 1'b0;
    tick(2);
    check({waveform_start_trigger, pin_lvl[10]}, 2'b00);
    waveform_running = 1'b1;
    waveform_begin   = 1'b1;
    tick(1);
    waveform_begin = 1'b0;
    wait_on(2, 1'b1);
    check({pin_lvl[10], waveform_start_pin_oe_n}, 2'b10);
  endtask : t_wave

  // Conversion then update: rest high, one low pulse, high again
  task automatic t_conv;
    for (int k = 3; k < 5; k++) begin
      check(watch[k], 1'b1);
      {dac_update_event, adc_convert_event} = (k == 3) ? 2'b01 : 2'b10;
      tick(1);
      {dac_update_event, adc_convert_event} = 2'b00;
      wait_on(k, 1'b0);
      measure(k, 1'b0);
      check(watch[k], 1'b1);
    end
  endtask : t_conv

  task automatic t_echo;
    {ctr_source_dir, ctr_gate_dir, ctr_source_sel, ctr_gate_sel} = 8'hff;
    for (int k = 0; k < 16; k += 5) begin
      {counter1_gate_echo_in, counter1_source_echo_in,
       counter0_gate_echo_in, counter0_source_echo_in} = k[3:0];
      tick(2);
      check({counter1_gate_echo, counter1_source_echo, counter0_gate_echo,
             counter0_source_echo}, k[3:0]);
    end
    check({counter0_source_echo_oe_n, counter0_gate_echo_oe_n, counter1_source_echo_oe_n,
           counter1_gate_echo_oe_n}, 4'h0);
    {ctr_source_dir, ctr_gate_dir, ctr_source_sel, ctr_gate_sel} = 8'h05;
    tick(2);
    check({counter1_gate_echo, counter1_source_echo, counter0_gate_echo,
           counter0_source_echo}, 4'h3);
    check({counter0_source_echo_oe_n, counter1_source_echo_oe_n}, 2'b11);
  endtask : t_echo

  task automatic t_result;
    for (int k = 0; k < 8; k++) begin
      {freq_gen_out, counter1_out_int, counter0_out_int} = k[2:0];
      tick(2);
      check({divided_clock_output, counter1_result, counter0_result}, k[2:0]);
    end
    // Pin levels: echoes high, line seven high, markers driven high, start pin low
    function_input_seven = 1'b1;
    tick(2);
    check(func_in_levels, 8'hfe);
  endtask : t_result

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {general_lines_data, general_lines_dir, ctr_dir_from_line, ctr_dir_internal} = '0;
    {ctr_source_dir, ctr_gate_dir, ctr_source_sel, ctr_gate_sel, strobe_toggle} = '0;
    {acq_start_pin_dir, acq_start_from_pin, acq_start_internal, posttrig_pin_dir} = '0;
    {pretrigger_marker, acq_running, posttrig_begin, adc_convert_event} = '0;
    {dac_update_event, waveform_pin_dir, waveform_running, waveform_begin} = '0;
    {counter0_source_echo_in, counter0_gate_echo_in, counter1_source_echo_in} = '0;
    {counter1_gate_echo_in, counter0_out_int, counter1_out_int, freq_gen_out} = '0;
    {function_input_seven, ext_en, ext_val} = '0;
    tick(4);
    t_reset();
    nrst = 1'b1;
    tick(1);
    t_strobe();
    t_lines();
    t_start();
    t_post();
    t_wave();
    t_conv();
    t_echo();
    t_result();
    complete_run();
  end
endmodule : dct_connector_io_tb_top
